// ---- verilog/acb_map.svh ----
/*
 * Register offsets, field positions, reset values and error codes of the axis control handshake.
 * Assumes a 32-bit APB slave with byte addresses; each register is one aligned word.
 */
`ifndef ACB_MAP_SVH
`define ACB_MAP_SVH

`define ACB_NAXES 4
`define ACB_NBITS 8

`define ACB_OFF_CTRL 8'h00
`define ACB_OFF_IMAGE 8'h04
`define ACB_OFF_ERR 8'h08
`define ACB_OFF_ENA 8'h0C
`define ACB_OFF_JOB0 8'h10
`define ACB_OFF_JOB3 8'h1C
`define ACB_OFF_ISTAT 8'h20
`define ACB_OFF_IMASK 8'h24
`define ACB_OFF_RUN 8'h28

`define ACB_BIT_START 0
`define ACB_BIT_STOP 1
`define ACB_BIT_JOGF 6
`define ACB_BIT_JOGR 7

`define ACB_RST_WORD 32'h0000_0000
`define ACB_RST_ENA 4'hF
`define ACB_RST_CNT 16'h0000
`define ACB_RST_IRQ 8'h00

`define ACB_ERR_OK 8'h00
`define ACB_ERR_DISABLED 8'h01
`define ACB_ERR_BUSY 8'h02
`define ACB_ERR_NOJOB 8'h03
`define ACB_ERR_UNSUP 8'h04
`define ACB_ERR_JOGBOTH 8'h05

`endif

// ---- verilog/acb_pkg.sv ----
/*
 * Types of the axis control handshake block: state encoding, APB request carrier, verdict record.
 * Assumes the constants of acb_map.svh for widths of fields.
 */
package acb_pkg;

   typedef enum logic [1:0] {
      ACB_IDLE = 2'b00,
      ACB_INTERP = 2'b01,
      ACB_START = 2'b11
   } acb_state_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } acb_apb_req_t;

   typedef struct packed {
      logic ok;
      logic [7:0] code;
   } acb_verdict_t;

endpackage : acb_pkg

// ---- verilog/acb_axis_ctrl.sv ----
/*
 * Per-axis control bit handshake of a four-axis positioning block, reached over APB.
 * Assumes one 25 MHz clock shared with the APB master, synchronous active-low reset.
 */
// The register addresses and the APB slave port are this design's own decisions.
// Functional notes
// - Image is set once the set bit is interpreted, errors or not.
// - Image is also set when the requested action is not permissible.
// - Image of an accepted bit clears only after the bit is cleared and the action completed.
// - Image also clears when the refused action's bit is cleared.
// - Operator error code per axis; zero means ok, nonzero refused or faulty.
// - Stored job is kept; setting start again repeats the traverse.
// - Bits arriving together are all interpreted first, then axes start together.
`timescale 1ns/1ns
`include "acb_map.svh"

module acb_axis_ctrl
   import acb_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input acb_apb_req_t apbReq,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output logic [3:0] axisRun,
   output logic [3:0] jogFwd,
   output logic [3:0] jogRev
);

   ////////////////////////////////////////////////////////////////////////////
   // Decoding shared by the read and write paths

   function automatic logic isJob(input logic [7:0] a);
      isJob = (a >= `ACB_OFF_JOB0) && (a <= `ACB_OFF_JOB3) && (a[1:0] == 2'h0);
   endfunction : isJob

   function automatic logic isMapped(input logic [7:0] a);
      isMapped = isJob(a) || (a == `ACB_OFF_CTRL) || (a == `ACB_OFF_IMAGE) || (a == `ACB_OFF_ERR)
         || (a == `ACB_OFF_ENA) || (a == `ACB_OFF_ISTAT) || (a == `ACB_OFF_IMASK) || (a == `ACB_OFF_RUN);
   endfunction : isMapped

   // Judges one axis' pending byte; busy means a traverse or jog is running
   function automatic acb_verdict_t judge(input logic [7:0] p, input logic en, input logic busy,
      input logic [15:0] jobLen);
      judge.ok = 1'b0;
      judge.code = `ACB_ERR_OK;
      if (!en)
         judge.code = `ACB_ERR_DISABLED;
      else if ((p[`ACB_BIT_START] || p[`ACB_BIT_JOGF] || p[`ACB_BIT_JOGR]) && busy)
         judge.code = `ACB_ERR_BUSY;
      else if (p[`ACB_BIT_START] && (jobLen == `ACB_RST_CNT))
         judge.code = `ACB_ERR_NOJOB;
      else if (p[`ACB_BIT_JOGF] && p[`ACB_BIT_JOGR])
         judge.code = `ACB_ERR_JOGBOTH;
      else if (|p[5:2])
         judge.code = `ACB_ERR_UNSUP;
      else
         judge.ok = 1'b1;
   endfunction : judge

   ////////////////////////////////////////////////////////////////////////////
   // State

   acb_state_t state;
   logic [31:0] ctrl;
   logic [31:0] image;
   logic [31:0] pend;
   logic [31:0] refused;
   logic [31:0] errWord;
   logic [3:0] ena;
   logic [3:0][15:0] job;
   logic [3:0][15:0] travCnt;
   logic [3:0] jogging;
   acb_verdict_t [3:0] verdictQ;
   logic [7:0] istat;
   logic [7:0] imask;
   logic [31:0] rdVal;

   wire logic access = apbReq.psel && apbReq.penable;
   wire logic take = access && pready;
   wire logic wrEn = take && apbReq.pwrite;
   wire logic [31:0] newReq = ctrl & ~image;
   wire logic [31:0] next_image;
   wire logic [31:0] next_refused;
   wire logic [3:0][15:0] next_travCnt;
   wire logic [3:0] next_jogging;
   wire acb_verdict_t [3:0] verdict;
   wire logic [7:0] evtSet;

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state, answer registered

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `ACB_RST_WORD;
      end
      else
      begin
         pready <= access && !pready;
         pslverr <= access && !pready && !isMapped(apbReq.paddr);
         if (access && !pready)
            prdata <= apbReq.pwrite ? `ACB_RST_WORD : rdVal;
      end
   end

   always_comb
   begin
      rdVal = `ACB_RST_WORD;
      if (apbReq.paddr == `ACB_OFF_CTRL)
         rdVal = ctrl;
      else if (apbReq.paddr == `ACB_OFF_IMAGE)
         rdVal = image;
      else if (apbReq.paddr == `ACB_OFF_ERR)
         rdVal = errWord;
      else if (apbReq.paddr == `ACB_OFF_ENA)
         rdVal = {28'h0, ena};
      else if (isJob(apbReq.paddr))
         rdVal = {16'h0, job[apbReq.paddr[3:2]]};
      else if (apbReq.paddr == `ACB_OFF_ISTAT)
         rdVal = {24'h0, istat};
      else if (apbReq.paddr == `ACB_OFF_IMASK)
         rdVal = {24'h0, imask};
      else if (apbReq.paddr == `ACB_OFF_RUN)
         rdVal = {20'h0, jogging, 4'h0, axisRun};
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software registers

   // A write to the control word is the transfer of all axes' bits at once
   always_ff @(posedge clk)
   begin
      if (!rstn)
         ctrl <= `ACB_RST_WORD;
      else if (wrEn && (apbReq.paddr == `ACB_OFF_CTRL))
         ctrl <= apbReq.pwdata;
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         ena <= `ACB_RST_ENA;
      else if (wrEn && (apbReq.paddr == `ACB_OFF_ENA))
         ena <= apbReq.pwdata[3:0];
   end

   // Jobs survive traverses, so a repeated start reuses them
   always_ff @(posedge clk)
   begin
      if (!rstn)
         job <= '0;
      else if (wrEn && isJob(apbReq.paddr))
         job[apbReq.paddr[3:2]] <= apbReq.pwdata[15:0];
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         imask <= `ACB_RST_IRQ;
      else if (wrEn && (apbReq.paddr == `ACB_OFF_IMASK))
         imask <= apbReq.pwdata[7:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer: capture, interpret every axis, then start together

   always_ff @(posedge clk)
   begin
      if (!rstn)
         state <= ACB_IDLE;
      else
         case (state)
            ACB_IDLE: if (|newReq) state <= ACB_INTERP;
            ACB_INTERP: state <= ACB_START;
            ACB_START: state <= ACB_IDLE;
            default: state <= ACB_IDLE;
         endcase
   end

   // Only bits with a zero image open a handshake; others are ignored
   always_ff @(posedge clk)
   begin
      if (!rstn)
         pend <= `ACB_RST_WORD;
      else if (state == ACB_IDLE && |newReq)
         pend <= newReq;
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         verdictQ <= '0;
      else if (state == ACB_INTERP)
         verdictQ <= verdict;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-axis and per-bit handshake

   for (genvar a = 0; a < `ACB_NAXES; a++)
   begin : g_axis
      wire logic [7:0] p = pend[a*8 +: 8];
      wire logic go = (state == ACB_START) && (|p);
      wire logic busy = (travCnt[a] != `ACB_RST_CNT) || jogging[a];
      wire logic jogHeld = ctrl[a*8 + `ACB_BIT_JOGF] || ctrl[a*8 + `ACB_BIT_JOGR];
      assign verdict[a] = judge(p, ena[a], busy, job[a]);
      assign evtSet[a] = go;
      assign evtSet[a + 4] = go && !verdictQ[a].ok;
      // Traverse length counts down in clocks; stop ends it at once
      assign next_travCnt[a] =
         (go && verdictQ[a].ok && p[`ACB_BIT_STOP]) ? `ACB_RST_CNT :
         (go && verdictQ[a].ok && p[`ACB_BIT_START]) ? job[a] :
         (travCnt[a] != `ACB_RST_CNT) ? travCnt[a] - 16'h0001 : travCnt[a];
      // Jog lasts while either direction bit is held
      assign next_jogging[a] = (go && verdictQ[a].ok && (p[`ACB_BIT_JOGF] || p[`ACB_BIT_JOGR])) ||
         (jogging[a] && jogHeld);
      for (genvar b = 0; b < `ACB_NBITS; b++)
      begin : g_bit
         localparam int I = a * 8 + b;
         wire logic actDone = (b == `ACB_BIT_START) ? (travCnt[a] == `ACB_RST_CNT) :
            (b == `ACB_BIT_JOGF || b == `ACB_BIT_JOGR) ? !jogHeld : 1'b1;
         wire logic relBit = image[I] && !ctrl[I] && (refused[I] || actDone);
         // Set on interpretation, accepted or refused; cleared on release
         assign next_image[I] = (go && p[b]) ? 1'b1 :
            relBit ? 1'b0 : image[I];
         assign next_refused[I] = (go && p[b]) ? !verdictQ[a].ok :
            relBit ? 1'b0 : refused[I];
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         image <= `ACB_RST_WORD;
         refused <= `ACB_RST_WORD;
      end
      else
      begin
         image <= next_image;
         refused <= next_refused;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         travCnt <= '0;
         jogging <= 4'h0;
      end
      else
      begin
         travCnt <= next_travCnt;
         jogging <= next_jogging;
      end
   end

   // Operator error code per axis, refreshed by each interpreted request
   always_ff @(posedge clk)
   begin
      if (!rstn)
         errWord <= `ACB_RST_WORD;
      else
         for (int a = 0; a < `ACB_NAXES; a++)
            if (state == ACB_START && |pend[a*8 +: 8])
               errWord[a*8 +: 8] <= verdictQ[a].code;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs and interrupt

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         axisRun <= 4'h0;
         jogFwd <= 4'h0;
         jogRev <= 4'h0;
      end
      else
         for (int a = 0; a < `ACB_NAXES; a++)
         begin
            axisRun[a] <= (next_travCnt[a] != `ACB_RST_CNT) || next_jogging[a];
            jogFwd[a] <= next_jogging[a] && ctrl[a*8 + `ACB_BIT_JOGF];
            jogRev[a] <= next_jogging[a] && ctrl[a*8 + `ACB_BIT_JOGR];
         end
   end

   // Event set wins over a write-one clear in the same cycle
   always_ff @(posedge clk)
   begin
      if (!rstn)
         istat <= `ACB_RST_IRQ;
      else if (wrEn && (apbReq.paddr == `ACB_OFF_ISTAT))
         istat <= (istat & ~apbReq.pwdata[7:0]) | evtSet;
      else
         istat <= istat | evtSet;
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         irq <= 1'b0;
      else
         irq <= |(istat & imask);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_newReq;
      state == ACB_IDLE && (|newReq);
   endsequence
   sequence s_interpStart;
      state == ACB_INTERP ##1 state == ACB_START;
   endsequence
   property p_ack_set;
      s_newReq |=> s_interpStart ##1 ((image & pend) == pend);
   endproperty
   a_ack_set: assert property (p_ack_set) else $error("image not set after request");
   // Axis 1 is the one the bench disables, so the refusal path is reached
   property p_refused_ack;
      (state == ACB_START && !verdictQ[1].ok && |pend[15:8])
         |=> ((image[15:8] & pend[15:8]) == pend[15:8]) && ((refused[15:8] & pend[15:8]) == pend[15:8]);
   endproperty
   a_refused_ack: assert property (p_refused_ack) else $error("refused request not acknowledged");
   property p_image_hold;
      (image[0] && (ctrl[0] || (travCnt[0] != 16'h0000 && !refused[0]))) |=> image[0];
   endproperty
   a_image_hold: assert property (p_image_hold) else $error("image cleared too early");
   property p_refused_release;
      (image[8] && refused[8] && !ctrl[8]) |=> !image[8] ##1 !image[8] [*2];
   endproperty
   a_refused_release: assert property (p_refused_release) else $error("refused image not released");
   property p_err_code;
      (state == ACB_START && |pend[7:0]) |=> errWord[7:0] == $past(verdictQ[0].code);
   endproperty
   a_err_code: assert property (p_err_code) else $error("operator error code wrong");
   property p_job_reuse;
      (state == ACB_START && pend[0] && verdictQ[0].ok && !pend[1]) |=> travCnt[0] == $past(job[0]);
   endproperty
   a_job_reuse: assert property (p_job_reuse) else $error("stored job not used");
   property p_joint_start;
      (state == ACB_START && pend[0] && pend[8] && verdictQ[0].ok && verdictQ[1].ok && !pend[1] && !pend[9])
         |=> axisRun[0] && axisRun[1] && $rose(axisRun[0]) == $rose(axisRun[1]);
   endproperty
   a_joint_start: assert property (p_joint_start) else $error("axes did not start together");
   property p_image_only_start;
      (state != ACB_START) |=> ((image & ~$past(image)) == 32'h0000_0000);
   endproperty
   a_image_only_start: assert property (p_image_only_start) else $error("image set outside start");
   property p_ready_again;
      (image[8] && !ctrl[8] && travCnt[1] == 16'h0000) |=> !image[8];
   endproperty
   a_ready_again: assert property (p_ready_again) else $error("image did not return to zero");

endmodule : acb_axis_ctrl

// ---- verif/acb_host_model.sv ----
/*
 * APB master model standing in for the controller's cyclic transfer block.
 * Assumes the slave raises pready; a hung wait is cut by the bench watchdog.
 */
`timescale 1ns/1ns

module acb_host_model
   import acb_pkg::*;
(
   input wire logic clk,
   output acb_apb_req_t apbReq,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);

   initial apbReq = '0;

   // Request held unchanged until pready is sampled high
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
      output logic [31:0] rdata, output logic err);
      @(posedge clk);
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
      @(posedge clk);
      apbReq.penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      // Released lines show no stale value
      apbReq <= '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, paddr: ~addr, pwdata: ~wdata};
   endtask : xfer

endmodule : acb_host_model

// ---- verif/axis_control_bit_handshake_tb_top.sv ----
/*
 * Self-checking bench of the axis control handshake: reset values, refusals, traverse, jog, joint start.
 * Assumes the APB master model in acb_host_model.sv and the map in acb_map.svh.
 */
`timescale 1ns/1ns
`include "acb_map.svh"

module axis_control_bit_handshake_tb_top
   import acb_pkg::*;
;

   logic clk = 1'b0;
   logic rstn = 1'b0;
   acb_apb_req_t apbReq;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic [3:0] axisRun;
   logic [3:0] jogFwd;
   logic [3:0] jogRev;
   logic [31:0] rd;
   logic er;
   logic irqOn;
   int miscompares = 0;
   int checksDone = 0;
   int seed = 91186;
   logic [31:0] errAcc = 32'h0000_0000;

   always #20 clk = ~clk;

   acb_host_model host_u (.clk(clk), .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   acb_axis_ctrl dut_u (.clk(clk), .rstn(rstn), .apbReq(apbReq), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .axisRun(axisRun), .jogFwd(jogFwd), .jogRev(jogRev));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      if (miscompares == 0 && checksDone > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp)
      begin
         $display("BAD %s exp %h got %h", nm, exp, got);
         miscompares++;
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host_u.xfer(1'b1, a, d, rd, er);
   endtask : wr

   task automatic rdr(input logic [7:0] a);
      host_u.xfer(1'b0, a, 32'h0000_0000, rd, er);
   endtask : rdr

   task automatic waitImg(input logic [31:0] exp);
      int n;
      n = 0;
      rdr(`ACB_OFF_IMAGE);
      while (rd !== exp && n < 60)
      begin
         rdr(`ACB_OFF_IMAGE);
         n++;
      end
   endtask : waitImg

   // Axes that must move: accepted start or jog bits
   function automatic logic [3:0] expRun(input logic [31:0] c, input logic [31:0] e);
      logic [3:0] r;
      for (int a = 0; a < 4; a++)
         r[a] = (e[8*a+:8] == 8'h00) && (c[8*a] || c[8*a+6] || c[8*a+7]);
      return r;
   endfunction : expRun

   // Axes that must jog in direction bit b
   function automatic logic [3:0] expJog(input logic [31:0] c, input logic [31:0] e, input int b);
      logic [3:0] r;
      for (int a = 0; a < 4; a++)
         r[a] = (e[8*a+:8] == 8'h00) && c[8*a+b];
      return r;
   endfunction : expJog

   function automatic logic [31:0] expRefuse(input logic [31:0] e);
      logic [31:0] r;
      r = 32'h0000_0000;
      for (int a = 0; a < 4; a++)
         r[4+a] = (e[8*a+:8] != 8'h00);
      return r;
   endfunction : expRefuse

   task automatic job(input logic [31:0] c, input logic [31:0] e);
      logic [3:0] seen;
      logic [3:0] fwd;
      logic [3:0] rev;
      seen = 4'h0;
      fwd = 4'h0;
      rev = 4'h0;
      waitImg(32'h0000_0000);
      wr(`ACB_OFF_CTRL, c);
      for (int n = 0; n < 8 && seen == 4'h0; n++)
      begin
         @(posedge clk);
         seen = axisRun | jogFwd | jogRev;
         fwd = jogFwd;
         rev = jogRev;
      end
      chk("axisRun", {28'h0, expRun(c, e)}, {28'h0, seen});
      chk("jogFwd", {28'h0, expJog(c, e, 6)}, {28'h0, fwd});
      chk("jogRev", {28'h0, expJog(c, e, 7)}, {28'h0, rev});
      waitImg(c);
      chk("image", c, rd);
      rdr(`ACB_OFF_ERR);
      // Error bytes of axes not addressed keep their last code
      for (int a = 0; a < 4; a++)
         if (c[8*a+:8] != 8'h00)
            errAcc[8*a+:8] = e[8*a+:8];
      chk("err", errAcc, rd);
      chk("irq", {31'h0, irqOn}, {31'h0, irq});
      rdr(`ACB_OFF_ISTAT);
      chk("istatRefuse", expRefuse(e), rd & 32'h0000_00F0);
      wr(`ACB_OFF_ISTAT, 32'h0000_00FF);
      rdr(`ACB_OFF_ISTAT);
      chk("istatClr", 32'h0000_0000, rd);
      chk("irqClr", 32'h0000_0000, {31'h0, irq});
      // Jog bits held up to here, then dropped with the others
      wr(`ACB_OFF_CTRL, 32'h0000_0000);
      waitImg(32'h0000_0000);
      chk("imageClr", 32'h0000_0000, rd);
   endtask : job

   ////////////////////////////////////////////////////////////////////////////////
   logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h24, 8'h28};
   logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h0, 32'hF, 32'h0, 32'h0, 32'h0, 32'h0};
   logic [31:0] cc [10] = '{32'h2, 32'h1, 32'h1, 32'h101, 32'h4000_0000, 32'h100, 32'h1_0000,
      32'h4_0000, 32'hC000_0000, 32'h0080_0000};
   logic [31:0] ce [10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h100, 32'h3_0000, 32'h4_0000,
      32'h0500_0000, 32'h0};

   initial
   begin
      logic [31:0] len;
      irqOn = 1'b0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         rdr(ra[i]);
         chk("resetValue", rv[i], rd);
      end
      rdr(8'h40);
      chk("slverr", 32'h1, {31'h0, er});
      chk("unmapped", 32'h0, rd);
      wr(`ACB_OFF_IMAGE, 32'hFFFF_FFFF);
      rdr(`ACB_OFF_IMAGE);
      chk("imageRO", 32'h0, rd);
      for (int i = 0; i < 10; i++)
      begin
         // Job data rewritten only before the first start and before the joint start, so the repeat reuses it
         if (i == 0 || i == 3)
         begin
            len = ($unsigned($random(seed)) % 16) + 1;
            wr(`ACB_OFF_JOB0, len);
            wr(8'h14, len + 32'h1);
            rdr(`ACB_OFF_JOB0);
            chk("job0", len, rd);
         end
         if (i == 1)
         begin
            wr(`ACB_OFF_IMASK, 32'h0000_00FF);
            irqOn = 1'b1;
         end
         if (i == 5)
            wr(`ACB_OFF_ENA, 32'h0000_000D);
         job(cc[i], ce[i]);
      end
      stop_test();
   end

   initial
   begin
      #(40 * 30000);
      miscompares++;
      stop_test();
   end

endmodule : axis_control_bit_handshake_tb_top
